// ---- pin_mgmt_pkg.sv ----
// Shared constants and types for the PIN management command block
package pin_mgmt_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_GO     = 8'h04;
    localparam logic [7:0] ADDR_DATA0  = 8'h08;
    localparam logic [7:0] ADDR_DATA1  = 8'h0C;
    localparam logic [7:0] ADDR_DATA2  = 8'h10;
    localparam logic [7:0] ADDR_DATA3  = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_PSTATE = 8'h1C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_P1_LSB    = 8;
    localparam int CMD_P2_LSB    = 16;
    localparam int CMD_EMPTY_BIT = 24;
    localparam int GO_BIT        = 0;
    localparam int ST_BUSY_BIT   = 16;
    localparam int ST_DONE_BIT   = 17;

    // ************************************************************
    // Counter and qualifier values
    // ************************************************************
    localparam logic [1:0] PIN_TRIES_INIT = 2'h3;
    localparam logic [3:0] UNB_TRIES_INIT = 4'hA;
    localparam logic [7:0] UQ_USE         = 8'h08;
    localparam logic [7:0] UQ_DO_NOT_USE  = 8'h00;
    localparam logic [7:0] P1_RESERVED    = 8'h01;
    localparam int         P1_REPL_BIT    = 7;

    // ************************************************************
    // Status words
    // ************************************************************
    localparam logic [15:0] SW_OK        = 16'h9000;
    localparam logic [11:0] SW_RETRY_HI  = 12'h63C;
    localparam logic [15:0] SW_BLOCKED   = 16'h6983;
    localparam logic [15:0] SW_COND      = 16'h6985;
    localparam logic [15:0] SW_BAD_PARAM = 16'h6A86;
    localparam logic [15:0] SW_BAD_LEN   = 16'h6700;
    localparam logic [15:0] SW_RESET     = 16'h0000;

    typedef enum logic [1:0] {
        OP_DISABLE   = 2'h0,
        OP_ENABLE    = 2'h1,
        OP_UNBLOCK   = 2'h2,
        OP_PROVISION = 2'h3
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b11
    } state_t;

    typedef struct packed {
        logic       empty;
        logic [7:0] p2;
        logic [7:0] p1;
        op_t        op;
    } cmd_t;

endpackage

// ---- pin_mgmt.sv ----
// PIN disable, enable and unblock command engine with APB registers
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
module pin_mgmt #(
    parameter int NUM_REFS        = 32,
    parameter bit ENABLE_ON_BLOCK = 1'b0
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             o_revalidate
);

    // ************************************************************
    // Non-volatile reference store (survives card reset)
    // ************************************************************
    logic [63:0] pin_val  [NUM_REFS];
    logic [63:0] ukey_val [NUM_REFS];
    logic [1:0]  pin_cnt  [NUM_REFS];
    logic [3:0]  unb_cnt  [NUM_REFS];
    logic        pin_en   [NUM_REFS];
    logic [7:0]  usage_q  [NUM_REFS];
    logic [4:0]  repl_key [NUM_REFS];
    logic        repl_v   [NUM_REFS];

    // ************************************************************
    // Session registers
    // ************************************************************
    pin_mgmt_pkg::cmd_t   cmd_r;
    pin_mgmt_pkg::state_t state_r;
    pin_mgmt_pkg::state_t state_nxt;
    logic [31:0] data_r [4];
    logic [15:0] sw_r;
    logic [15:0] sw_nxt;
    logic        done_r;
    logic        reval_r;
    logic [31:0] prdata_r;

    function automatic logic [15:0] retry_sw(input logic [3:0] cnt);
        retry_sw = {pin_mgmt_pkg::SW_RETRY_HI, cnt};
    endfunction

    // ************************************************************
    // APB decode
    // ************************************************************
    wire setup    = psel && !penable;
    wire access   = psel && penable;
    wire busy     = (state_r != pin_mgmt_pkg::ST_IDLE);
    wire hit_cmd  = (paddr == pin_mgmt_pkg::ADDR_CMD);
    wire hit_go   = (paddr == pin_mgmt_pkg::ADDR_GO);
    wire hit_st   = (paddr == pin_mgmt_pkg::ADDR_STATUS);
    wire hit_ps   = (paddr == pin_mgmt_pkg::ADDR_PSTATE);
    wire hit_data = (paddr >= pin_mgmt_pkg::ADDR_DATA0) &&
                    (paddr <= pin_mgmt_pkg::ADDR_DATA3) &&
                    (paddr[1:0] == 2'h0);
    wire [1:0] data_idx = 2'(paddr[7:2] - 6'h02);
    wire mapped   = hit_cmd || hit_go || hit_st || hit_ps || hit_data;
    wire wr_ok    = access && pwrite && mapped && !busy;
    wire go       = wr_ok && hit_go && pwdata[pin_mgmt_pkg::GO_BIT];

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_r;

    // ************************************************************
    // Command field decode
    // ************************************************************
    wire [4:0] ref_n   = cmd_r.p2[4:0];
    wire [4:0] key_n   = cmd_r.p1[4:0];
    wire       ref_ok  = (ref_n != 5'h00) && (cmd_r.p2[6:5] == 2'h0);
    wire [63:0] pin_in = {data_r[0], data_r[1]};
    wire [63:0] new_in = {data_r[2], data_r[3]};
    wire       pin_ok  = (pin_in == pin_val[ref_n]);
    wire       ukey_ok = (pin_in == ukey_val[ref_n]);
    wire       blocked = (pin_cnt[ref_n] == 2'h0);
    wire       enabled = pin_en[ref_n];
    wire       ublock  = (unb_cnt[ref_n] == 4'h0);
    wire [1:0] pin_dec = blocked ? 2'h0 : 2'(pin_cnt[ref_n] - 2'h1);
    wire [3:0] unb_dec = ublock ? 4'h0 : 4'(unb_cnt[ref_n] - 4'h1);
    wire       p1_repl = cmd_r.p1[pin_mgmt_pkg::P1_REPL_BIT];
    wire       dis_p1_ok = (cmd_r.p1 == 8'h00) ||
                           (p1_repl && cmd_r.p1[6:5] == 2'h0 &&
                            key_n != 5'h00);
    wire       exec = (state_r == pin_mgmt_pkg::ST_EXEC);
    wire       is_dis  = (cmd_r.op == pin_mgmt_pkg::OP_DISABLE);
    wire       is_en   = (cmd_r.op == pin_mgmt_pkg::OP_ENABLE);
    wire       is_unb  = (cmd_r.op == pin_mgmt_pkg::OP_UNBLOCK);
    wire       is_prov = (cmd_r.op == pin_mgmt_pkg::OP_PROVISION);

    // Parameter and length checks come before state checks
    wire bad_param = !ref_ok || (is_dis && !dis_p1_ok) ||
                     (is_en && cmd_r.p1 != 8'h00) ||
                     (is_unb && cmd_r.p1 != 8'h00);
    wire bad_len   = cmd_r.empty && !is_unb;
    wire legal     = !bad_param && !bad_len;
    wire dis_refuse = is_dis && (!enabled || blocked);
    wire en_refuse  = is_en && (enabled || blocked);

    // ************************************************************
    // Action strobes, valid only in the execute cycle
    // ************************************************************
    wire dis_try  = exec && legal && is_dis && !dis_refuse;
    wire en_try   = exec && legal && is_en && !en_refuse;
    wire dis_good = dis_try && pin_ok;
    wire en_good  = en_try && pin_ok;
    wire pin_bad  = (dis_try || en_try) && !pin_ok;
    wire unb_try  = exec && legal && is_unb && !cmd_r.empty &&
                    !ublock;
    wire unb_good = unb_try && ukey_ok;
    wire unb_bad  = unb_try && !ukey_ok;
    wire prov     = exec && is_prov && ref_ok;
    wire set_en_on_block = ENABLE_ON_BLOCK && en_try && !pin_ok &&
                           (pin_dec == 2'h0);

    // ************************************************************
    // Status word selection
    // ************************************************************
    always_comb begin
        sw_nxt = sw_r;
        if (exec) begin
            if (bad_param && !is_prov) begin
                sw_nxt = pin_mgmt_pkg::SW_BAD_PARAM;
            end else if (bad_len && !is_prov) begin
                sw_nxt = pin_mgmt_pkg::SW_BAD_LEN;
            end else if (is_prov) begin
                sw_nxt = ref_ok ? pin_mgmt_pkg::SW_OK
                                : pin_mgmt_pkg::SW_BAD_PARAM;
            end else if (dis_refuse || en_refuse) begin
                sw_nxt = pin_mgmt_pkg::SW_COND;
            end else if (is_unb && cmd_r.empty) begin
                sw_nxt = retry_sw(unb_cnt[ref_n]);
            end else if (is_unb && ublock) begin
                sw_nxt = pin_mgmt_pkg::SW_BLOCKED;
            end else if (unb_bad) begin
                sw_nxt = retry_sw(unb_dec);
            end else if (pin_bad) begin
                sw_nxt = retry_sw({2'h0, pin_dec});
            end else begin
                sw_nxt = pin_mgmt_pkg::SW_OK;
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        unique case (state_r)
            pin_mgmt_pkg::ST_IDLE:
                state_nxt = go ? pin_mgmt_pkg::ST_EXEC : pin_mgmt_pkg::ST_IDLE;
            pin_mgmt_pkg::ST_EXEC: state_nxt = pin_mgmt_pkg::ST_DONE;
            pin_mgmt_pkg::ST_DONE: state_nxt = pin_mgmt_pkg::ST_IDLE;
            default:               state_nxt = pin_mgmt_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= pin_mgmt_pkg::ST_IDLE;
            sw_r    <= pin_mgmt_pkg::SW_RESET;
            done_r  <= 1'b0;
            reval_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sw_r    <= sw_nxt;
            done_r  <= go ? 1'b0 : (done_r || exec);
            reval_r <= dis_good || en_good || unb_good;
        end
    end

    assign o_revalidate = reval_r;

    // ************************************************************
    // Software-written command and data registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_r <= '0;
        end else if (wr_ok && hit_cmd) begin
            cmd_r.op    <= pin_mgmt_pkg::op_t'(
                               pwdata[pin_mgmt_pkg::CMD_OP_LSB +: 2]);
            cmd_r.p1    <= pwdata[pin_mgmt_pkg::CMD_P1_LSB +: 8];
            cmd_r.p2    <= pwdata[pin_mgmt_pkg::CMD_P2_LSB +: 8];
            cmd_r.empty <= pwdata[pin_mgmt_pkg::CMD_EMPTY_BIT];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_data
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    data_r[gi] <= 32'h0000_0000;
                end else if (wr_ok && hit_data && data_idx == 2'(gi)) begin
                    data_r[gi] <= pwdata;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Read data, captured in the setup phase
    // ************************************************************
    wire access_free = !enabled && !repl_v[ref_n];
    wire [31:0] st_word = {14'h0000, done_r, busy, sw_r};
    wire [31:0] ps_word = {8'h00, usage_q[key_n], 1'b0, repl_v[ref_n],
                           repl_key[ref_n], access_free, unb_cnt[ref_n],
                           blocked, enabled, pin_cnt[ref_n]};
    wire [31:0] rd_word = hit_cmd  ? {7'h00, cmd_r.empty, cmd_r.p2,
                                      cmd_r.p1, 6'h00, cmd_r.op} :
                          hit_st   ? st_word :
                          hit_ps   ? ps_word :
                          hit_data ? data_r[data_idx] : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_r <= rd_word;
        end
    end

    // ************************************************************
    // Reference store updates; no reset, so counts persist
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (prov) begin
            pin_val[ref_n]  <= pin_in;
            ukey_val[ref_n] <= new_in;
            pin_cnt[ref_n]  <= pin_mgmt_pkg::PIN_TRIES_INIT;
            unb_cnt[ref_n]  <= pin_mgmt_pkg::UNB_TRIES_INIT;
            pin_en[ref_n]   <= 1'b1;
            repl_v[ref_n]   <= 1'b0;
            repl_key[ref_n] <= 5'h00;
            usage_q[ref_n]  <= pin_mgmt_pkg::UQ_DO_NOT_USE;
        end
        if (dis_good) begin
            pin_cnt[ref_n] <= pin_mgmt_pkg::PIN_TRIES_INIT;
            pin_en[ref_n]  <= 1'b0;
            if (p1_repl) begin
                usage_q[key_n]  <= pin_mgmt_pkg::UQ_USE;
                repl_key[ref_n] <= key_n;
                repl_v[ref_n]   <= 1'b1;
            end
        end
        if (en_good) begin
            pin_cnt[ref_n] <= pin_mgmt_pkg::PIN_TRIES_INIT;
            pin_en[ref_n]  <= 1'b1;
            if (repl_v[ref_n]) begin
                usage_q[repl_key[ref_n]] <= pin_mgmt_pkg::UQ_DO_NOT_USE;
                repl_v[ref_n] <= 1'b0;
            end
        end
        if (pin_bad) begin
            pin_cnt[ref_n] <= pin_dec;
        end
        if (set_en_on_block) begin
            pin_en[ref_n] <= 1'b1;
        end
        if (unb_good) begin
            pin_val[ref_n] <= new_in;
            unb_cnt[ref_n] <= pin_mgmt_pkg::UNB_TRIES_INIT;
            pin_cnt[ref_n] <= pin_mgmt_pkg::PIN_TRIES_INIT;
            pin_en[ref_n]  <= 1'b1;
        end
        if (unb_bad) begin
            unb_cnt[ref_n] <= unb_dec;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_disable_ok_state: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        dis_good |=> (pin_cnt[ref_n] == 2'h3) && !pin_en[ref_n])
        else $error("disable did not reset tries or clear enable");

    a_disable_bad_dec: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (dis_try && !pin_ok) |=>
            (pin_cnt[ref_n] == $past(pin_cnt[ref_n]) - 2'h1) &&
            pin_en[ref_n])
        else $error("wrong disable PIN not decremented");

    a_block_sw_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (pin_bad && pin_cnt[ref_n] == 2'h1) |=>
            (sw_r == 16'h63C0) && (pin_cnt[ref_n] == 2'h0))
        else $error("third wrong PIN did not block");

    a_refuse_keeps: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (exec && legal && (dis_refuse || en_refuse)) |=>
            $stable(pin_cnt[ref_n]) && (sw_r == 16'h6985))
        else $error("refused command changed state");

    a_repl_qualifier: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (dis_good && p1_repl) |=> (usage_q[key_n] == 8'h08))
        else $error("replacement key qualifier not set");

    a_revalidate_pulse: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (dis_good || en_good || unb_good) |=> o_revalidate ##1
            !o_revalidate)
        else $error("revalidate not a single pulse");

    a_enable_clears: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (en_good && repl_v[ref_n]) |=>
            (usage_q[$past(repl_key[ref_n])] == 8'h00) && !repl_v[ref_n])
        else $error("enable did not clear replacement");

    a_unblock_good: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        unb_good |=> (unb_cnt[ref_n] == 4'hA) &&
            (pin_cnt[ref_n] == 2'h3) && pin_en[ref_n] &&
            (sw_r == 16'h9000))
        else $error("unblock did not restore counters");

    a_unblock_bad: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        unb_bad |=> $stable(pin_cnt[ref_n]) && $stable(pin_en[ref_n]) &&
            (sw_r == {12'h63C, $past(unb_cnt[ref_n]) - 4'h1}))
        else $error("bad unblock key touched PIN or wrong status");

    a_unblock_locked: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (exec && legal && is_unb && !cmd_r.empty && ublock) |=>
            (sw_r == 16'h6983) && (unb_cnt[ref_n] == 4'h0))
        else $error("blocked unblock key not reported");

    a_empty_query: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (exec && legal && is_unb && cmd_r.empty) |=>
            (sw_r == {12'h63C, $past(unb_cnt[ref_n])}) &&
            $stable(unb_cnt[ref_n]))
        else $error("empty unblock query wrong status or count");

    a_bad_param: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (exec && bad_param && !is_prov) |=>
            (sw_r == 16'h6A86) && !o_revalidate)
        else $error("bad parameter not refused");

    a_enable_bad_keeps: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (en_try && !pin_ok) |=>
            (pin_en[ref_n] ==
             (ENABLE_ON_BLOCK && ($past(pin_cnt[ref_n]) == 2'h1))))
        else $error("wrong enable PIN changed enable state");

endmodule

// ---- terminal_model.sv ----
// Terminal-side APB master that issues card commands
`timescale 1ns/10ps
module terminal_model (
    input  wire logic        i_clk,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    input  wire logic [31:0] i_prdata,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata
);
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0;
    end

    // ************************************************************
    // One APB transfer, held until pready is seen at an edge
    // ************************************************************
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        q   = i_prdata;
        err = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_paddr   <= ~a;
        o_pwdata  <= ~d;
    endtask

    // ************************************************************
    // Full command: header, eight-byte value pair, start, poll
    // ************************************************************
    task automatic run(input logic [31:0] c, input logic [63:0] v,
                       input logic [63:0] nv, output logic [15:0] sw);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, pin_mgmt_pkg::ADDR_CMD, c, q, e);
        xfer(1'b1, pin_mgmt_pkg::ADDR_DATA0, v[63:32], q, e);
        xfer(1'b1, pin_mgmt_pkg::ADDR_DATA1, v[31:0], q, e);
        xfer(1'b1, pin_mgmt_pkg::ADDR_DATA2, nv[63:32], q, e);
        xfer(1'b1, pin_mgmt_pkg::ADDR_DATA3, nv[31:0], q, e);
        xfer(1'b1, pin_mgmt_pkg::ADDR_GO, 32'h1, q, e);
        do begin
            xfer(1'b0, pin_mgmt_pkg::ADDR_STATUS, 32'h0, q, e);
        end while (q[pin_mgmt_pkg::ST_BUSY_BIT] !== 1'b0 ||
                   q[pin_mgmt_pkg::ST_DONE_BIT] !== 1'b1);
        sw = q[15:0];
    endtask
endmodule

// ---- pin_enable_disable_unblock_bench.sv ----
// Self-checking bench for the PIN disable, enable and unblock engine
`timescale 1ns/10ps
module pin_enable_disable_unblock_bench;
    localparam pin_mgmt_pkg::op_t DIS = pin_mgmt_pkg::OP_DISABLE;
    localparam pin_mgmt_pkg::op_t ENA = pin_mgmt_pkg::OP_ENABLE;
    localparam pin_mgmt_pkg::op_t UNB = pin_mgmt_pkg::OP_UNBLOCK;
    localparam pin_mgmt_pkg::op_t PRV = pin_mgmt_pkg::OP_PROVISION;
    localparam logic [15:0] OK = pin_mgmt_pkg::SW_OK;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, o_revalidate;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [63:0] pin_a, puk_a, pin_n, pin_b, puk_b;
    logic [4:0]  ref_a, ref_b, key;
    logic        err;
    int          num_errors = 0, comparisons = 0, cycles = 0, pulses = 0;
    int          seed = 26;

    always #25 i_clk = ~i_clk;

    pin_mgmt u_pin_mgmt (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .o_revalidate(o_revalidate));
    terminal_model u_terminal_model (.i_clk(i_clk), .i_pready(pready),
        .i_pslverr(pslverr), .i_prdata(prdata), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata));

    always @(posedge i_clk) begin
        cycles++;
        if (o_revalidate === 1'b1) pulses++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] retry_sw(input logic [3:0] n);
        return {pin_mgmt_pkg::SW_RETRY_HI, n};
    endfunction
    function automatic logic [31:0] view(input logic [1:0] t,
        input logic en, input logic [3:0] u, input logic fr);
        return {23'h0, fr, u, t == 2'h0, en, t};
    endfunction
    // Runs a command and checks status word, and revalidate pulse unless provisioning
    task automatic cmd(input pin_mgmt_pkg::op_t op, input logic [7:0] p1,
        input logic [4:0] r, input logic emp, input logic [63:0] v,
        input logic [63:0] nv, input logic [15:0] exp_sw);
        logic [15:0] sw;
        int          p0;
        p0 = pulses;
        u_terminal_model.run({7'h0, emp, 3'h0, r, p1, 6'h0, op}, v, nv, sw);
        check({16'h0, sw}, {16'h0, exp_sw});
        if (op != PRV) check(pulses - p0, (exp_sw == OK) ? 1 : 0);
    endtask
    task automatic pstate(input logic [4:0] r, input logic [4:0] k);
        u_terminal_model.xfer(1'b1, pin_mgmt_pkg::ADDR_CMD,
                              {11'h0, r, 3'h0, k, 8'h00}, q, err);
        u_terminal_model.xfer(1'b0, pin_mgmt_pkg::ADDR_PSTATE, 32'h0, q, err);
    endtask
    task automatic pview(input logic [4:0] r, input logic [31:0] exp);
        pstate(r, 5'h0);
        check({23'h0, q[8:0]}, exp);
    endtask
    task automatic bump_reset();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        ref_a = 5'(($unsigned($random(seed)) % 31) + 1);
        ref_b = 5'((ref_a % 31) + 1);
        key   = 5'(($unsigned($random(seed)) % 31) + 1);
        pin_a = {$random(seed), $random(seed)};
        puk_a = {$random(seed), $random(seed)};
        pin_n = {$random(seed), $random(seed)};
        pin_b = {$random(seed), $random(seed)};
        puk_b = {$random(seed), $random(seed)};
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        cmd(PRV, 8'h00, ref_a, 1'b0, pin_a, puk_a, OK);
        cmd(DIS, 8'h00, ref_a, 1'b0, ~pin_a, 64'h0, retry_sw(4'h2));
        pview(ref_a, view(2'h2, 1'b1, 4'hA, 1'b0));
        cmd(DIS, 8'h00, ref_a, 1'b0, pin_a, 64'h0, OK);
        pview(ref_a, view(2'h3, 1'b0, 4'hA, 1'b1));
        cmd(DIS, 8'h00, ref_a, 1'b0, pin_a, 64'h0, 16'h6985);
        cmd(ENA, 8'h00, ref_a, 1'b0, ~pin_a, 64'h0, retry_sw(4'h2));
        pview(ref_a, view(2'h2, 1'b0, 4'hA, 1'b1));
        cmd(ENA, 8'h00, ref_a, 1'b0, pin_a, 64'h0, OK);
        pview(ref_a, view(2'h3, 1'b1, 4'hA, 1'b0));
        cmd(ENA, 8'h00, ref_a, 1'b0, pin_a, 64'h0, 16'h6985);
        $display("Disable and enable basics done");
        cmd(DIS, 8'h01, ref_a, 1'b0, pin_a, 64'h0, 16'h6A86);
        cmd(DIS, {3'h2, key}, ref_a, 1'b0, pin_a, 64'h0, 16'h6A86);
        cmd(DIS, 8'h80, ref_a, 1'b0, pin_a, 64'h0, 16'h6A86);
        cmd(DIS, 8'h00, 5'h00, 1'b0, pin_a, 64'h0, 16'h6A86);
        cmd(DIS, {3'h4, key}, ref_a, 1'b0, pin_a, 64'h0, OK);
        pstate(ref_a, key);
        check({16'h0, q[23:16], 1'b0, q[14:8]},
              {24'h08, 2'h1, key, 1'b0});
        cmd(ENA, 8'h00, ref_a, 1'b0, pin_a, 64'h0, OK);
        pstate(ref_a, key);
        check({24'h0, q[23:16]}, 32'h0);
        $display("Replacement key handling done");
        cmd(DIS, 8'h00, ref_a, 1'b0, ~pin_a, 64'h0, retry_sw(4'h2));
        cmd(DIS, 8'h00, ref_a, 1'b0, ~pin_a, 64'h0, retry_sw(4'h1));
        bump_reset();
        cmd(DIS, 8'h00, ref_a, 1'b0, ~pin_a, 64'h0, retry_sw(4'h0));
        pview(ref_a, view(2'h0, 1'b1, 4'hA, 1'b0));
        cmd(DIS, 8'h00, ref_a, 1'b0, pin_a, 64'h0, 16'h6985);
        cmd(ENA, 8'h00, ref_a, 1'b0, pin_a, 64'h0, 16'h6985);
        $display("Blocking across resets done");
        cmd(UNB, 8'h00, ref_a, 1'b1, 64'h0, 64'h0, retry_sw(4'hA));
        cmd(UNB, 8'h00, ref_a, 1'b0, ~puk_a, pin_n, retry_sw(4'h9));
        pview(ref_a, view(2'h0, 1'b1, 4'h9, 1'b0));
        cmd(UNB, 8'h00, ref_a, 1'b0, puk_a, pin_n, OK);
        pview(ref_a, view(2'h3, 1'b1, 4'hA, 1'b0));
        cmd(DIS, 8'h00, ref_a, 1'b0, pin_n, 64'h0, OK);
        for (int i = 2; i >= 0; i--) begin
            cmd(ENA, 8'h00, ref_a, 1'b0, ~pin_n, 64'h0, retry_sw(4'(i)));
        end
        pview(ref_a, view(2'h0, 1'b0, 4'hA, 1'b1));
        $display("Unblock and disabled blocking done");
        cmd(PRV, 8'h00, ref_b, 1'b0, pin_b, puk_b, OK);
        for (int i = 9; i >= 0; i--) begin
            cmd(UNB, 8'h00, ref_b, 1'b0, ~puk_b, pin_n, retry_sw(4'(i)));
        end
        cmd(UNB, 8'h00, ref_b, 1'b0, puk_b, pin_n, 16'h6983);
        cmd(UNB, 8'h00, ref_b, 1'b1, 64'h0, 64'h0, retry_sw(4'h0));
        pview(ref_a, view(2'h0, 1'b0, 4'hA, 1'b1));
        u_terminal_model.xfer(1'b0, 8'h40, 32'h0, q, err);
        check({err, q[30:0]}, 32'h80000000);
        $display("Unblock key exhaustion done");
        final_report();
    end
endmodule
